/* File: hdl/hsr_pkg.sv */
// Purpose: shared constants and carriers for halt state and status reporting
// Assumes: single clock domain, plain-port control and status
// Notes:   status codes are 8-bit, completion record codes as encoded
package hsr_pkg;

  // --------------------------------------------------------------
  // status codes
  // --------------------------------------------------------------
  localparam logic [7:0] ST_NONE      = 8'h00;
  localparam logic [7:0] ST_SUCCESS   = 8'h01;
  localparam logic [7:0] ST_FALSE_PRED = 8'h02;
  localparam logic [7:0] ST_PART_PF   = 8'h03;
  localparam logic [7:0] ST_PART_IRR  = 8'h04;
  localparam logic [7:0] ST_BATCH_FAIL = 8'h05;
  localparam logic [7:0] ST_BATCH_PF  = 8'h06;
  localparam logic [7:0] ST_DELTA_ORDER = 8'h07;
  localparam logic [7:0] ST_DELTA_RANGE = 8'h08;
  localparam logic [7:0] ST_DIF_ERR   = 8'h09;
  localparam logic [7:0] ST_CR_PF     = 8'h1a;
  localparam logic [7:0] ST_CR_ALIGN  = 8'h1b;
  localparam logic [7:0] ST_PRIV_DIS  = 8'h1d;

  // completion record address alignment (32 bytes -> low 5 bits)
  localparam int CR_ALIGN_BITS = 5;

  // --------------------------------------------------------------
  // device state and reset kind encodings
  // --------------------------------------------------------------
  localparam logic [1:0] DEV_ENABLED = 2'h1;
  localparam logic [1:0] DEV_HALTED  = 2'h2;
  localparam logic [1:0] DEV_DISABLED = 2'h0;

  localparam logic [1:0] RST_DEVICE_CMD = 2'h0;
  localparam logic [1:0] RST_FLR        = 2'h1;
  localparam logic [1:0] RST_WARM       = 2'h2;
  localparam logic [1:0] RST_COLD       = 2'h3;

  // reset values
  localparam logic [7:0] SWERR_RST = 8'h00;
  localparam logic [7:0] CR_RST    = 8'h00;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic       cfg_change;   // unsupported config change, e.g. bme drop
    logic       reg_parity;   // parity error on register write
    logic       buf_parity;   // parity error on internal buffer
    logic       fabric_sev;   // severe internal fabric error
  } hsr_halt_cause_s;

  typedef struct packed {
    logic        is_batch;
    logic        is_delta_apply;
    logic        is_dif;        // dif check, strip or update
    logic        cr_valid;      // completion record address valid flag
    logic        block_on_fault;
    logic        priv;
    logic [63:0] cr_addr;
  } hsr_desc_s;

  typedef struct packed {
    logic pf_partial;      // page fault, operation partial
    logic pr_invalid;      // invalid-request response to page request
    logic batch_sub_fail;  // a batch member did not succeed
    logic list_pf;         // unresolved fault on descriptor list
    logic delta_order;     // delta offsets not increasing
    logic delta_range;     // delta offset >= transfer size
    logic dif_err;
    logic cr_pf;           // completion record translation failed
    logic false_pred;
  } hsr_result_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] status;
  } hsr_report_s;

endpackage : hsr_pkg

/* File: hdl/hsr_status_enc.sv */
// Purpose: derive operation status code from descriptor and outcome
// Assumes: inputs are stable while valid
// Notes:   purely combinational, priority highest fault first
`timescale 1ns/1ns
module hsr_status_enc (
  input  hsr_pkg::hsr_desc_s   desc,
  input  hsr_pkg::hsr_result_s res,
  input  wire logic            priv_mode_en,
  output logic [7:0]           status
);

  // ------------------------------------------------------------
  // fault detection
  // ------------------------------------------------------------
  wire logic cr_misalign;
  wire logic priv_bad;
  assign cr_misalign = desc.cr_valid &&
                       (desc.cr_addr[hsr_pkg::CR_ALIGN_BITS-1:0] != '0);
  assign priv_bad    = desc.priv && !priv_mode_en;

  // priority encode, descriptor faults before operation outcome
  always_comb begin
    if (priv_bad)
      status = hsr_pkg::ST_PRIV_DIS;
    else if (cr_misalign)
      status = hsr_pkg::ST_CR_ALIGN;
    else if (desc.cr_valid && res.cr_pf)
      status = hsr_pkg::ST_CR_PF;
    else if (desc.is_batch && res.list_pf)
      status = hsr_pkg::ST_BATCH_PF;
    else if (desc.is_delta_apply && res.delta_order)
      status = hsr_pkg::ST_DELTA_ORDER;
    else if (desc.is_delta_apply && res.delta_range)
      status = hsr_pkg::ST_DELTA_RANGE;
    else if (desc.is_dif && res.dif_err)
      status = hsr_pkg::ST_DIF_ERR;
    else if (res.pr_invalid)
      status = hsr_pkg::ST_PART_IRR;
    else if (res.pf_partial && !desc.block_on_fault)
      status = hsr_pkg::ST_PART_PF;
    else if (desc.is_batch && res.batch_sub_fail)
      status = hsr_pkg::ST_BATCH_FAIL;
    else if (res.false_pred)
      status = hsr_pkg::ST_FALSE_PRED;
    else
      status = hsr_pkg::ST_SUCCESS;
  end

endmodule : hsr_status_enc

/* File: hdl/hsr_route.sv */
// Purpose: choose completion record or error log for a status code
// Assumes: combinational decision, registered by the caller
// Notes:   error log wins when both could apply
`timescale 1ns/1ns
module hsr_route (
  input  wire logic [7:0] status,
  input  wire logic       cr_valid,
  output logic            to_log,
  output logic            to_cr
);

  // codes always logged, and codes allowed without a record
  wire logic forced_log;
  wire logic no_cr_ok;
  assign forced_log = (status == hsr_pkg::ST_CR_PF) ||
                      (status == hsr_pkg::ST_CR_ALIGN) ||
                      (status == hsr_pkg::ST_PRIV_DIS);
  assign no_cr_ok   = (status == hsr_pkg::ST_SUCCESS) ||
                      (status == hsr_pkg::ST_FALSE_PRED) ||
                      (status == hsr_pkg::ST_BATCH_FAIL);

  // route selection
  assign to_log = forced_log || (!cr_valid && !no_cr_ok);
  assign to_cr  = cr_valid && !forced_log;

endmodule : hsr_route

/* File: hdl/hsr_halt_unit.sv */
// Purpose: halt state control and per-descriptor status reporting
// Assumes: one 25 MHz clock, async active-low reset, plain ports
// Notes:   halt is left only through nrst or a reset-device command
`timescale 1ns/1ns

// What this block does
// - status port shows device state, halted included
// - status port shows reset kind needed
// - halt entry pulses interrupt vector 0 if enabled
// - halt entry sets interrupt cause halt flag
// - config change, parity, fabric errors cause halt
// - data parity goes to aer, no halt
// - halted: upstream reads and writes blocked
// - halted: register read completions continue unless severe
// - halted: every enqueue gets retry answer
// - halted: invalidation completions unless severe or reset
// - halt leaves only through the reported reset
// - valid record gets status in its field
// - codes 1a, 1b, 1d go to error log
// - no record, not 01/02/05: log it
// - 01 success, 02 false predicate
// - 03 partial on page fault, no block
// - 04 partial on invalid page request response
// - 05 batch member failed, batch only
// - 06 batch list fault unresolved
// - 07 delta offsets out of order
// - 08 delta offset beyond transfer size
// - 09 dif error on check, strip, update
// - 1b completion record not 32-byte aligned
// - 1d privileged request while privilege disabled
module hsr_halt_unit (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // halt causes and control
  input  hsr_pkg::hsr_halt_cause_s    halt_cause,
  input  wire logic                   data_parity_err,
  input  wire logic                   pcie_reset_active,
  input  wire logic                   reset_device_cmd,
  input  wire logic                   halt_int_en,
  input  wire logic                   cause_clr,
  input  wire logic                   dev_enable,
  // upstream request gating
  input  wire logic                   up_req_valid,
  output logic                        up_req_valid_out,
  // register read completions
  input  wire logic                   reg_rd_cpl_valid,
  output logic                        reg_rd_cpl_valid_out,
  // invalidation completions
  input  wire logic                   inv_cpl_valid,
  output logic                        inv_cpl_valid_out,
  // descriptor submission
  input  wire logic                   enq_unpriv,
  input  wire logic                   enq_super,
  output logic                        enq_accept,
  output logic                        enq_retry,
  // descriptor completion
  input  wire logic                   op_done,
  input  hsr_pkg::hsr_desc_s          op_desc,
  input  hsr_pkg::hsr_result_s        op_res,
  input  wire logic                   priv_mode_en,
  output hsr_pkg::hsr_report_s        cr_write,
  output logic [7:0]                  software_error_log,
  output logic                        swerr_valid,
  input  wire logic                   swerr_clr,
  // status and interrupt
  output logic [1:0]                  dev_state,
  output logic [1:0]                  reset_type_needed,
  output logic                        halt_cause_flag,
  output logic                        msix_vec0_req,
  output logic                        aer_data_parity
);

  // ------------------------------------------------------------
  // device state machine
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    HSR_DISABLED = 3'b001,
    HSR_ENABLED  = 3'b010,
    HSR_HALTED   = 3'b100
  } hsr_state_e;

  hsr_state_e state_ff;
  hsr_state_e nxt_state;
  logic [1:0] rst_kind_ff;
  logic [1:0] nxt_rst_kind;
  logic       severe_ff;
  logic       cause_ff;
  logic       irq_ff;
  logic       aer_ff;
  logic [7:0] swerr_ff;
  logic       swerr_v_ff;
  hsr_pkg::hsr_report_s cr_ff;

  // halt causes; data parity is not among them
  wire logic any_cause;
  wire logic halted;
  wire logic enter_halt;
  assign any_cause  = halt_cause.cfg_change | halt_cause.reg_parity |
                      halt_cause.buf_parity | halt_cause.fabric_sev;
  assign halted     = (state_ff == HSR_HALTED);
  assign enter_halt = any_cause && !halted;

  // reset kind ranking by cause severity
  always_comb begin
    if (halt_cause.fabric_sev)
      nxt_rst_kind = hsr_pkg::RST_WARM;
    else if (halt_cause.buf_parity)
      nxt_rst_kind = hsr_pkg::RST_FLR;
    else
      nxt_rst_kind = hsr_pkg::RST_DEVICE_CMD;
  end

  // next state; only a reset-device command leaves halt in-band
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      HSR_DISABLED: begin
        if (any_cause)
          nxt_state = HSR_HALTED;
        else if (dev_enable)
          nxt_state = HSR_ENABLED;
      end
      HSR_ENABLED: begin
        if (any_cause)
          nxt_state = HSR_HALTED;
        else if (!dev_enable)
          nxt_state = HSR_DISABLED;
      end
      HSR_HALTED: begin
        if (reset_device_cmd &&
            rst_kind_ff == hsr_pkg::RST_DEVICE_CMD)
          nxt_state = HSR_DISABLED;
      end
      default: nxt_state = HSR_DISABLED;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= HSR_DISABLED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // reset kind and severity latched on entry
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_kind_ff <= hsr_pkg::RST_DEVICE_CMD;
      severe_ff   <= 1'b0;
    end else if (enter_halt) begin
      rst_kind_ff <= nxt_rst_kind;
      severe_ff   <= halt_cause.fabric_sev;
    end else if (!halted) begin
      severe_ff   <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt cause and vector request
  // ------------------------------------------------------------
  // set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cause_ff <= 1'b0;
      irq_ff   <= 1'b0;
    end else begin
      cause_ff <= enter_halt | (cause_ff & ~cause_clr);
      irq_ff   <= enter_halt & halt_int_en;
    end
  end

  // data parity reported upstream, no halt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aer_ff <= 1'b0;
    end else begin
      aer_ff <= data_parity_err;
    end
  end

  // ------------------------------------------------------------
  // traffic gating while halted
  // ------------------------------------------------------------
  assign up_req_valid_out     = up_req_valid & ~halted;
  assign reg_rd_cpl_valid_out = reg_rd_cpl_valid &
                                ~(halted & severe_ff);
  assign inv_cpl_valid_out    = inv_cpl_valid &
                                ~(halted & (severe_ff |
                                  pcie_reset_active));

  // enqueue answers
  wire logic enq_any;
  assign enq_any     = enq_unpriv | enq_super;
  assign enq_retry   = enq_any & (halted |
                       state_ff == HSR_DISABLED);
  assign enq_accept  = enq_any & (state_ff == HSR_ENABLED);

  // ------------------------------------------------------------
  // status encode and route
  // ------------------------------------------------------------
  logic [7:0] op_status;
  logic       route_log;
  logic       route_cr;

  hsr_status_enc u_enc (
    .desc         (op_desc),
    .res          (op_res),
    .priv_mode_en (priv_mode_en),
    .status       (op_status)
  );

  hsr_route u_route (
    .status   (op_status),
    .cr_valid (op_desc.cr_valid),
    .to_log   (route_log),
    .to_cr    (route_cr)
  );

  // completion record write, one-cycle pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cr_ff <= '{valid: 1'b0, status: hsr_pkg::CR_RST};
    end else begin
      cr_ff.valid <= op_done & route_cr & ~halted;
      if (op_done & route_cr)
        cr_ff.status <= op_status;
    end
  end

  // error log; new entry wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      swerr_ff   <= hsr_pkg::SWERR_RST;
      swerr_v_ff <= 1'b0;
    end else if (op_done & route_log) begin
      swerr_ff   <= op_status;
      swerr_v_ff <= 1'b1;
    end else if (swerr_clr) begin
      swerr_v_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  assign dev_state = halted ? hsr_pkg::DEV_HALTED :
                     (state_ff == HSR_ENABLED) ? hsr_pkg::DEV_ENABLED :
                     hsr_pkg::DEV_DISABLED;
  assign reset_type_needed  = rst_kind_ff;
  assign halt_cause_flag    = cause_ff;
  assign msix_vec0_req      = irq_ff;
  assign aer_data_parity    = aer_ff;
  assign cr_write           = cr_ff;
  assign software_error_log = swerr_ff;
  assign swerr_valid        = swerr_v_ff;

endmodule : hsr_halt_unit

/* File: dv/hsr_halt_monitor.sv */
// Purpose: port checks for the halt unit
// Assumes: one clock, nrst async active low
// Notes:   bound to every hsr_halt_unit instance
`timescale 1ns/1ns
module hsr_halt_monitor (
  input wire logic                clk,
  input wire logic                nrst,
  input hsr_pkg::hsr_halt_cause_s halt_cause,
  input wire logic                data_parity_err,
  input wire logic                pcie_reset_active,
  input wire logic                reset_device_cmd,
  input wire logic                halt_int_en,
  input wire logic                up_req_valid,
  input wire logic                up_req_valid_out,
  input wire logic                inv_cpl_valid,
  input wire logic                inv_cpl_valid_out,
  input wire logic                enq_unpriv,
  input wire logic                enq_super,
  input wire logic                enq_accept,
  input wire logic                enq_retry,
  input wire logic                op_done,
  input hsr_pkg::hsr_desc_s       op_desc,
  input wire logic                priv_mode_en,
  input hsr_pkg::hsr_report_s     cr_write,
  input wire logic [7:0]          software_error_log,
  input wire logic                swerr_valid,
  input wire logic [1:0]          dev_state,
  input wire logic [1:0]          reset_type_needed,
  input wire logic                halt_cause_flag,
  input wire logic                msix_vec0_req,
  input wire logic                aer_data_parity
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // halted decode
  logic halted;
  assign halted = (dev_state == hsr_pkg::DEV_HALTED);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_up_gate: assert property (
    up_req_valid_out == (up_req_valid && !halted))
    else $error("upstream request not gated");
  a_enq_retry: assert property (
    (enq_unpriv || enq_super) && halted |-> enq_retry && !enq_accept)
    else $error("enqueue while halted not retried");
  a_halt_irq: assert property (
    !halted ##1 halted |-> msix_vec0_req == $past(halt_int_en))
    else $error("halt interrupt wrong on entry");
  a_irq_at_entry: assert property (
    msix_vec0_req |-> halted && !$past(halted))
    else $error("interrupt outside halt entry");
  a_flag_on_entry: assert property (
    !halted ##1 halted |-> halt_cause_flag)
    else $error("cause flag not set on halt");
  a_cause_halts: assert property (
    (|halt_cause) && !halted |=> halted)
    else $error("halt cause did not halt");
  a_parity_aer: assert property (
    data_parity_err && !(|halt_cause) && !halted
    |=> aer_data_parity && !halted)
    else $error("data parity handled wrongly");
  a_halt_holds: assert property (
    halted && !(reset_device_cmd &&
    reset_type_needed == hsr_pkg::RST_DEVICE_CMD) |=> halted)
    else $error("halt left without reset");
  a_fabric_kind: assert property (
    halt_cause.fabric_sev && !halted
    |=> reset_type_needed == hsr_pkg::RST_WARM)
    else $error("wrong reset kind for fabric error");
  a_inv_block: assert property (
    halted && pcie_reset_active |-> !inv_cpl_valid_out)
    else $error("invalidation sent during link reset");
  a_priv_logged: assert property (
    op_done && op_desc.priv && !priv_mode_en |=> swerr_valid
    && software_error_log == hsr_pkg::ST_PRIV_DIS && !cr_write.valid)
    else $error("privilege fault not logged");

  // main scenarios reached
  c_halt_irq: cover property (!halted ##1 halted && msix_vec0_req);
  c_cr_write: cover property (op_done ##1 cr_write.valid);
  c_retry: cover property (halted && enq_retry);
endmodule : hsr_halt_monitor

bind hsr_halt_unit hsr_halt_monitor i_mon (.*);

/* File: dv/hsr_host_model.sv */
// Purpose: host side that submits work and resets
// Assumes: enqueue answer is combinational
// Notes:   reset command follows the reported kind
`timescale 1ns/1ns
module hsr_host_model (
  input  wire logic       clk,
  input  wire logic [1:0] reset_type_needed,
  input  wire logic       enq_accept,
  input  wire logic       enq_retry,
  output logic            enq_unpriv,
  output logic            enq_super,
  output logic            reset_device_cmd
);
  // idle at time zero
  initial begin
    enq_unpriv = 1'h0;
    enq_super = 1'h0;
    reset_device_cmd = 1'h0;
  end

  // one enqueue pulse, answer taken in its cycle
  task automatic submit(input logic sup, output logic [1:0] ans);
    @(posedge clk);
    enq_unpriv <= !sup;
    enq_super <= sup;
    #1;
    ans = {enq_accept, enq_retry};
    @(posedge clk);
    enq_unpriv <= 1'h0;
    enq_super <= 1'h0;
  endtask : submit

  // reset command only for that kind unless told otherwise
  task automatic recover(input logic obey);
    if (!obey || reset_type_needed == hsr_pkg::RST_DEVICE_CMD) begin
      @(posedge clk);
      reset_device_cmd <= 1'h1;
      @(posedge clk);
      reset_device_cmd <= 1'h0;
    end
  endtask : recover
endmodule : hsr_host_model

/* File: dv/hsr_halt_unit_tb_top.sv */
// Purpose: self-checking bench for the halt unit
// Assumes: 25 MHz clock, nrst async active low
// Notes:   one task per scenario
`timescale 1ns/1ns
module hsr_halt_unit_tb_top;
  localparam logic [63:0] AL = 64'h0000_0000_0000_1000;
  localparam logic [63:0] MA = 64'h0000_0000_0000_1010;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  hsr_pkg::hsr_halt_cause_s halt_cause = '0;
  logic data_parity_err = 1'h0, pcie_reset_active = 1'h0;
  logic halt_int_en = 1'h0, cause_clr = 1'h0, dev_enable = 1'h0;
  logic up_req_valid = 1'h1, reg_rd_cpl_valid = 1'h1;
  logic inv_cpl_valid = 1'h1, op_done = 1'h0;
  hsr_pkg::hsr_desc_s op_desc = '0;
  hsr_pkg::hsr_result_s op_res = '0;
  logic priv_mode_en = 1'h0, swerr_clr = 1'h0;
  logic enq_unpriv, enq_super, reset_device_cmd;
  logic up_req_valid_out, reg_rd_cpl_valid_out, inv_cpl_valid_out;
  logic enq_accept, enq_retry, swerr_valid, halt_cause_flag;
  logic msix_vec0_req, aer_data_parity;
  hsr_pkg::hsr_report_s cr_write;
  logic [7:0] software_error_log;
  logic [1:0] dev_state, reset_type_needed;
  int bad_count = 0;
  int total_checks = 0;

  always #20 clk = ~clk;

  hsr_halt_unit i_dut (.*);
  hsr_host_model i_host (.*);

  // compare and report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic do_reset();
    nrst <= 1'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
  endtask : do_reset

  // reset values, enqueue while disabled then enabled
  task automatic basics();
    logic [1:0] ans;
    #1;
    chk(dev_state, hsr_pkg::DEV_DISABLED);
    chk({halt_cause_flag, swerr_valid, cr_write.valid}, 8'h00);
    i_host.submit(1'h0, ans);
    chk(ans, 2'h1);
    dev_enable <= 1'h1;
    i_host.submit(1'h1, ans);
    chk(ans, 2'h2);
    chk(dev_state, hsr_pkg::DEV_ENABLED);
  endtask : basics

  // data parity goes to error reporting only
  task automatic parity_case();
    @(posedge clk);
    data_parity_err <= 1'h1;
    @(posedge clk);
    data_parity_err <= 1'h0;
    #1;
    chk(aer_data_parity, 1'h1);
    chk(dev_state, hsr_pkg::DEV_ENABLED);
    chk(up_req_valid_out, 1'h1);
    chk(reg_rd_cpl_valid_out, 1'h1);
    chk(inv_cpl_valid_out, 1'h1);
  endtask : parity_case

  // one descriptor completion and its routing
  task automatic do_op(input logic [5:0] f, input logic [63:0] a,
                       input logic [8:0] r, input logic [7:0] code);
    logic lg;
    lg = (code inside {8'h1a, 8'h1b, 8'h1d}) ||
         (!f[2] && !(code inside {8'h01, 8'h02, 8'h05}));
    @(posedge clk);
    op_desc <= hsr_pkg::hsr_desc_s'({f, a});
    op_res <= hsr_pkg::hsr_result_s'(r);
    op_done <= 1'h1;
    @(posedge clk);
    op_done <= 1'h0;
    #1;
    chk(cr_write.valid, f[2] && !lg);
    if (f[2] && !lg) chk(cr_write.status, code);
    chk(swerr_valid, lg);
    if (lg) chk(software_error_log, code);
    // clear the log entry on an edge, not between edges
    @(posedge clk);
    swerr_clr <= lg;
    @(posedge clk);
    swerr_clr <= 1'h0;
  endtask : do_op

  // every code with a completion record present
  task automatic status_codes();
    do_op(6'h04, AL, 9'h000, hsr_pkg::ST_SUCCESS);
    do_op(6'h04, AL, 9'h001, hsr_pkg::ST_FALSE_PRED);
    do_op(6'h04, AL, 9'h100, hsr_pkg::ST_PART_PF);
    do_op(6'h04, AL, 9'h080, hsr_pkg::ST_PART_IRR);
    do_op(6'h24, AL, 9'h040, hsr_pkg::ST_BATCH_FAIL);
    do_op(6'h24, AL, 9'h020, hsr_pkg::ST_BATCH_PF);
    do_op(6'h14, AL, 9'h010, hsr_pkg::ST_DELTA_ORDER);
    do_op(6'h14, AL, 9'h008, hsr_pkg::ST_DELTA_RANGE);
    do_op(6'h0c, AL, 9'h004, hsr_pkg::ST_DIF_ERR);
    do_op(6'h04, AL, 9'h002, hsr_pkg::ST_CR_PF);
    do_op(6'h04, MA, 9'h000, hsr_pkg::ST_CR_ALIGN);
    do_op(6'h05, AL, 9'h000, hsr_pkg::ST_PRIV_DIS);
  endtask : status_codes

  // no completion record: codes other than 01/02/05 are logged; last op is privileged with a record
  task automatic routing();
    do_op(6'h00, AL, 9'h000, hsr_pkg::ST_SUCCESS);
    do_op(6'h20, AL, 9'h040, hsr_pkg::ST_BATCH_FAIL);
    do_op(6'h00, AL, 9'h100, hsr_pkg::ST_PART_PF);
    do_op(6'h08, AL, 9'h004, hsr_pkg::ST_DIF_ERR);
    priv_mode_en <= 1'h1;
    do_op(6'h05, AL, 9'h000, hsr_pkg::ST_SUCCESS);
    priv_mode_en <= 1'h0;
  endtask : routing

  // enter halt by cause c, check behaviour, then recover
  task automatic halt_case(input logic [3:0] c, input logic ie,
                           input logic [1:0] k);
    logic [1:0] ans;
    @(posedge clk);
    halt_int_en <= ie;
    halt_cause <= hsr_pkg::hsr_halt_cause_s'(c);
    @(posedge clk);
    halt_cause <= '0;
    #1;
    chk(dev_state, hsr_pkg::DEV_HALTED);
    chk(halt_cause_flag, 1'h1);
    chk(msix_vec0_req, ie);
    chk(reset_type_needed, k);
    chk(up_req_valid_out, 1'h0);
    chk(reg_rd_cpl_valid_out, !c[0]);
    chk(inv_cpl_valid_out, !c[0]);
    @(posedge clk);
    pcie_reset_active <= 1'h1;
    cause_clr <= 1'h1;
    #1;
    chk(msix_vec0_req, 1'h0);
    chk(inv_cpl_valid_out, 1'h0);
    @(posedge clk);
    pcie_reset_active <= 1'h0;
    cause_clr <= 1'h0;
    #1;
    chk(halt_cause_flag, 1'h0);
    i_host.submit(1'h0, ans);
    chk(ans, 2'h1);
    i_host.submit(1'h1, ans);
    chk(ans, 2'h1);
    i_host.recover(1'h0);
    repeat (2) @(posedge clk);
    #1;
    chk(dev_state == hsr_pkg::DEV_HALTED, k != 2'h0);
    // mid-run reset starts on an edge; halt must be gone after it
    @(posedge clk);
    do_reset();
    #1;
    chk(dev_state, hsr_pkg::DEV_ENABLED);
    chk(reset_type_needed, hsr_pkg::RST_DEVICE_CMD);
    chk(halt_cause_flag, 1'h0);
  endtask : halt_case

  // hang guard
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end

  // main sequence
  initial begin
    do_reset();
    basics();
    parity_case();
    status_codes();
    routing();
    halt_case(4'h8, 1'h1, hsr_pkg::RST_DEVICE_CMD);
    halt_case(4'h4, 1'h0, hsr_pkg::RST_DEVICE_CMD);
    halt_case(4'h2, 1'h1, hsr_pkg::RST_FLR);
    halt_case(4'h1, 1'h1, hsr_pkg::RST_WARM);
    halt_case(4'h3, 1'h0, hsr_pkg::RST_WARM);
    end_sim();
  end
endmodule : hsr_halt_unit_tb_top
